// File: pvp_bclk_gen.sv
// Master bit clock and 8 kHz frame sync generator
`include "pvp_params.svh"
`default_nettype none
module pvp_bclk_gen
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic genEn,
  input  wire logic fastRate,
  output logic      bitClk,
  output logic      frameSync
);

  localparam logic [15:0] DEN      = 16'(`PVP_CLK_HZ / 1000);
  localparam logic [15:0] NUM_SLOW = 16'(2 * `PVP_BCLK_SLOW_HZ / 1000);
  localparam logic [15:0] NUM_FAST = 16'(2 * `PVP_BCLK_FAST_HZ / 1000);
  localparam logic [8:0]  LAST_SLOW = 9'(`PVP_BCLK_SLOW_HZ / `PVP_FRAME_HZ - 1);
  localparam logic [8:0]  LAST_FAST = 9'(`PVP_BCLK_FAST_HZ / `PVP_FRAME_HZ - 1);

  typedef struct packed {
    logic [15:0] acc;
    logic        bclk;
    logic        sync;
    logic [8:0]  cnt;
  } pvp_gen_state_type;

  pvp_gen_state_type s;
  pvp_gen_state_type n;

  logic [15:0] sum;
  logic [8:0]  last;

  // Fractional divider toggles the clock; sync covers the last bit of each frame
  always_comb
  begin
    n = s;
    last = fastRate ? LAST_FAST : LAST_SLOW;
    sum = s.acc + (fastRate ? NUM_FAST : NUM_SLOW);
    if (!genEn)
      n = '0;
    else if (sum >= DEN)
    begin
      n.acc = sum - DEN;
      n.bclk = ~s.bclk;
      if (!s.bclk)
      begin
        n.cnt = (s.cnt >= last) ? 9'h000 : s.cnt + 9'h001;
        n.sync = (n.cnt == last);
      end
    end
    else
      n.acc = sum;
  end

  // State register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s <= '0;
    else
      s <= n;
  end

  assign bitClk    = s.bclk;
  assign frameSync = s.sync;

endmodule
`default_nettype wire

// File: pvp_codec_model.sv
// Behavioural voice codec on the far side of the PCM bus
`default_nettype none
module pvp_codec_model
#(
  parameter int FRAME_BITS = 312
)
(
  input  wire logic        slaveMode,
  input  wire logic        wClk,
  input  wire logic        wSync,
  input  wire logic        wA,
  input  wire logic [15:0] rxWord,
  output logic             cClk,
  output logic             cSync,
  output logic             cB,
  output logic      [15:0] txSeen
);
  timeunit 1ns;
  timeprecision 100ps;
  int idx;
  int bitNum;
  // Free-running 400 ns link clock while the port is slave, odd phase
  initial
  begin
    idx = 16;
    bitNum = 0;
    cSync = 1'b0;
    cB = 1'b0;
    txSeen = 16'h0000;
    cClk = 1'b0;
    #37;
    forever #200 cClk = slaveMode ? ~cClk : 1'b0;
  end
  // sync high for the last bit of each frame
  always @(posedge cClk)
  begin
    bitNum = (bitNum == FRAME_BITS - 1) ? 0 : bitNum + 1;
    cSync <= (bitNum == FRAME_BITS - 1);
  end
  // B changes just after the rise, MSB first; fill toggles outside the slot
  always @(posedge wClk)
    cB <= (idx < 16) ? rxWord[15 - idx] : ~cB;
  // a sync seen at a fall starts a frame; line A taken on falls
  always @(negedge wClk)
  begin
    if (wSync)
      idx = 0;
    else if (idx < 16)
    begin
      txSeen <= {txSeen[14:0], wA};
      idx = idx + 1;
    end
  end
endmodule
`default_nettype wire

// File: pvp_law.sv
// Companding converter: linear to mu-law or A-law and back
`default_nettype none
module pvp_law
(
  input  wire logic [15:0] linIn,
  input  wire logic [7:0]  codeIn,
  input  wire logic        isAlaw,
  output logic      [7:0]  codeOut,
  output logic      [15:0] linOut
);

  // Linear 16-bit to 8-bit code
  function automatic logic [7:0] encode(input logic [15:0] x, input logic aLaw);
    logic        neg;
    logic [16:0] mag;
    logic [13:0] m;
    logic [2:0]  ex;
    logic [3:0]  mant;
    neg = x[15];
    mag = neg ? 17'(-{x[15], x}) : {1'b0, x};
    ex = 3'h0;
    if (aLaw)
    begin
      m = (mag[16:3] > 14'h0FFF) ? 14'h0FFF : mag[16:3];
      for (int e = 1; e < 8; e++)
        if (m[e + 4])
          ex = 3'(e);
      mant = (ex == 3'h0) ? m[4:1] : 4'(m >> ex);
      encode = {~neg, ex, mant} ^ 8'h55;
    end
    else
    begin
      m = (mag[16:2] > 15'h1FDE) ? 14'h1FDE : mag[15:2];
      m = 14'(m + 14'h0021);
      for (int e = 0; e < 8; e++)
        if (m[e + 5])
          ex = 3'(e);
      // Widened so segment seven shifts by eight, not by zero
      mant = 4'(m >> ({1'b0, ex} + 4'h1));
      encode = ~{neg, ex, mant};
    end
  endfunction

  // 8-bit code to linear 16-bit
  function automatic logic [15:0] decode(input logic [7:0] c, input logic aLaw);
    logic [7:0]  d;
    logic [15:0] t;
    logic        neg;
    if (aLaw)
    begin
      d = c ^ 8'h55;
      neg = ~d[7];
      if (d[6:4] == 3'h0)
        t = 16'({d[3:0], 4'h8});
      else
        t = 16'(({d[3:0], 4'h0} + 16'h0108) << (d[6:4] - 3'h1));
    end
    else
    begin
      d = ~c;
      neg = d[7];
      t = 16'((({d[3:0], 3'h0} + 16'h0084) << d[6:4]) - 16'h0084);
    end
    decode = neg ? 16'(-t) : t;
  endfunction

  // Both directions at once
  assign codeOut = encode(linIn, isAlaw);
  assign linOut  = decode(codeIn, isAlaw);

endmodule
`default_nettype wire

// File: pvp_params.svh
// Offsets, field reset values and timing figures of the PCM voice port
`ifndef PVP_PARAMS_SVH
`define PVP_PARAMS_SVH

// System clock and link rates in Hz
`define PVP_CLK_HZ          20000000
`define PVP_BCLK_SLOW_HZ    2000000
`define PVP_BCLK_FAST_HZ    2048000
`define PVP_FRAME_HZ        8000

// Register byte offsets on the Avalon slave
`define PVP_OFS_CTRL        8'h00
`define PVP_OFS_STATUS      8'h04
`define PVP_OFS_SLOT_BASE   8'h10
`define PVP_SLOT_STRIDE     8'h08
`define PVP_OFS_SLOT_DATA   8'h04

// Reset values: master, enabled, 2.048 MHz, line A output, 16-bit linear
`define PVP_CTRL_RESET      32'h0000100D
`define PVP_SLOT_RESET      32'h00000000

// Linear sample width limits and companded width
`define PVP_LIN_MIN         5'h0D
`define PVP_LIN_MAX         5'h10
`define PVP_LAW_BITS        5'h08

`endif

// File: pvp_pkg.sv
// Types shared by the PCM voice port modules
`default_nettype none
package pvp_pkg;

  // Codec-side sample format
  typedef enum logic [1:0] {
    FMT_LINEAR = 2'b00,
    FMT_MULAW  = 2'b01,
    FMT_ALAW   = 2'b10
  } pvp_fmt_type;

  // Encoding toward the radio link
  typedef enum logic [1:0] {
    AIR_CVSD  = 2'b00,
    AIR_ALAW  = 2'b01,
    AIR_MULAW = 2'b10
  } pvp_air_type;

  // Control register layout
  typedef struct packed {
    logic [16:0] rsvdHi;
    logic [1:0]  airEnc;
    logic [4:0]  linWidth;
    logic        rsvdLo;
    logic [1:0]  codecFmt;
    logic        bOut;
    logic        aOut;
    logic        fastRate;
    logic        slaveRole;
    logic        enable;
  } pvp_ctrl_type;

  // Per-timeslot configuration register layout
  typedef struct packed {
    logic [15:0] rsvdHi;
    logic [7:0]  startBit;
    logic [4:0]  rsvdLo;
    logic        rxOnB;
    logic        txOnB;
    logic        enable;
  } pvp_slot_cfg_type;

  // The four bus lines, used for inputs, outputs and enables alike
  typedef struct packed {
    logic clk;
    logic sync;
    logic a;
    logic b;
  } pvp_pins_type;

endpackage
`default_nettype wire

// File: pvp_tb.sv
// Self-checking bench for the PCM voice port
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic                  clk;
  logic                  rst;
  logic [7:0]            address;
  logic                  read;
  logic                  write;
  logic [31:0]           writedata;
  logic [3:0]            byteenable;
  logic [31:0]           readdata;
  logic                  waitrequest;
  pvp_pkg::pvp_pins_type pinIn;
  pvp_pkg::pvp_pins_type pinOut;
  pvp_pkg::pvp_pins_type pinOe;
  logic                  slaveMode;
  logic                  cClk;
  logic                  cSync;
  logic                  cB;
  logic [15:0]           rxWord;
  logic [15:0]           txSeen;
  logic [31:0]           rd;
  logic [31:0]           v;
  int                    fails;
  int                    num_checks;
  int                    bitCnt;
  int                    seed;
  // Each line carries the port while it drives, else the codec
  assign pinIn = {pinOe.clk ? pinOut.clk : cClk, pinOe.sync ? pinOut.sync : cSync,
                  pinOe.a ? pinOut.a : ~cB, pinOe.b ? pinOut.b : cB};
  pvp_voice_port u_dut
  (
    .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe)
  );
  pvp_codec_model u_codec
  (
    .slaveMode(slaveMode), .wClk(pinIn.clk), .wSync(pinIn.sync), .wA(pinIn.a),
    .rxWord(rxWord), .cClk(cClk), .cSync(cSync), .cB(cB), .txSeen(txSeen)
  );
  // System clock 50 ns
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Counts bit clock rises on the wire
  always @(posedge pinIn.clk)
    bitCnt++;
  task automatic results();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask
  // One Avalon access, held until waitrequest is seen low; only the watchdog ends a hang
  task automatic rw(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
    @(posedge clk);
    address <= adr;
    writedata <= wd;
    write <= wr;
    read <= ~wr;
    do
      @(posedge clk);
    while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  // Control readback: reserved bits zero, linear width clamped to 13..16
  function automatic logic [31:0] expCtrl(input logic [31:0] w);
    logic [31:0] e;
    e = w & 32'h00007F7F;
    if (e[12:8] < 5'h0D)
      e[12:8] = 5'h0D;
    else if (e[12:8] > 5'h10)
      e[12:8] = 5'h10;
    return e;
  endfunction
  task automatic frames(input int n);
    repeat (n) @(posedge pinIn.sync);
  endtask
  task automatic bits(input int exp);
    int b0;
    @(posedge pinIn.sync);
    #1 b0 = bitCnt;
    @(posedge pinIn.sync);
    #1 check("bits", 32'(bitCnt - b0), 32'(exp));
  endtask
  // One sample each way through slot 0: out on A, in on B
  task automatic xfer();
    logic [15:0] tx;
    tx = 16'($random(seed));
    rxWord = 16'($random(seed));
    rw(1'b1, 8'h14, {16'h0000, tx});
    frames(3);
    check("tx", {16'h0000, txSeen}, {16'h0000, tx});
    rw(1'b0, 8'h14, 32'h0);
    check("rx", {16'h0000, rd[15:0]}, {16'h0000, rxWord});
    check("cvsd", {24'h0, rd[23:16]}, 32'h0);
  endtask
  // Companded round trip: a decoded sample sent back gives the same code
  task automatic lawTrip(input logic [31:0] cv);
    logic [7:0] c;
    c = 8'($random(seed));
    // Negative zero of mu-law decodes to plus zero
    if (c == 8'h7F)
      c = 8'h7E;
    rxWord = {c, 8'h00};
    rw(1'b1, 8'h00, cv);
    frames(2);
    rw(1'b0, 8'h14, 32'h0);
    check("air", {24'h0, rd[23:16]}, {24'h0, c});
    rw(1'b1, 8'h14, {16'h0000, rd[15:0]});
    frames(2);
    check("law", {16'h0000, txSeen}, {16'h0000, c, 8'h00});
  endtask
  // Hang guard
  initial
  begin
    repeat (80000) @(posedge clk);
    fails++;
    results();
  end
  // Main sequence
  initial
  begin
    seed = 32'h6fdaa15e;
    fails = 0;
    num_checks = 0;
    bitCnt = 0;
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    slaveMode = 1'b0;
    address = 8'h00;
    writedata = 32'h0;
    byteenable = 4'hF;
    rxWord = 16'h0000;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rw(1'b0, 8'h00, 32'h0);
    check("ctrl", rd, 32'h0000100D);
    check("oe", {28'h0, pinOe}, 32'h0000000E);
    rw(1'b0, 8'h04, 32'h0);
    check("role", {31'h0, rd[1]}, 32'h0);
    rw(1'b1, 8'h08, $random(seed));
    rw(1'b0, 8'h08, 32'h0);
    check("hole", rd, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      v = $random(seed);
      rw(1'b1, 8'(8'h10 + 8 * i), v);
      rw(1'b0, 8'(8'h10 + 8 * i), 32'h0);
      check("slot", rd, v & 32'h0000FF07);
      rw(1'b1, 8'(8'h10 + 8 * i), (i == 0) ? 32'h5 : 32'h0);
    end
    for (int i = 0; i < 9; i++)
    begin
      v = {17'h0, 2'(i % 3), 5'(i + 10), 1'b0, 2'(i / 3), 5'h0D};
      rw(1'b1, 8'h00, v);
      rw(1'b0, 8'h00, 32'h0);
      check("fmt", rd, expCtrl(v));
    end
    rw(1'b1, 8'h00, 32'h0000100D);
    xfer();
    lawTrip(32'h0000304D);
    lawTrip(32'h0000502D);
    bits(256);
    rw(1'b1, 8'h00, 32'h00001009);
    frames(1);
    bits(250);
    rw(1'b1, 8'h00, 32'h0000100F);
    slaveMode <= 1'b1;
    repeat (4) @(posedge clk);
    check("slaveoe", {30'h0, pinOe.clk, pinOe.sync}, 32'h0);
    xfer();
    rw(1'b0, 8'h04, 32'h0);
    check("status", {30'h0, rd[1:0]}, 32'h3);
    results();
  end
endmodule
`default_nettype wire

// File: pvp_voice_port.sv
// PCM voice port: Avalon-MM registers, bus timing and up to three timeslots
//
// Register access over Avalon-MM and the register offsets were decided locally.
`include "pvp_params.svh"
`default_nettype none
module pvp_voice_port
#(
  parameter int NUM_SLOTS = 3
)
(
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic [7:0]          address,
  input  wire logic                read,
  input  wire logic                write,
  input  wire logic [31:0]         writedata,
  input  wire logic [3:0]          byteenable,
  output logic      [31:0]         readdata,
  output logic                     waitrequest,
  input  wire pvp_pkg::pvp_pins_type pinIn,
  output pvp_pkg::pvp_pins_type    pinOut,
  output pvp_pkg::pvp_pins_type    pinOe
);

  // Refuse slot counts the frame logic cannot serve
  if (NUM_SLOTS < 1 || NUM_SLOTS > 3)
  begin : gBadSlots
    $error("NUM_SLOTS must be 1 to 3");
  end

  localparam logic [7:0] SLOT_END =
    8'(`PVP_OFS_SLOT_BASE + NUM_SLOTS * `PVP_SLOT_STRIDE);

  typedef struct packed {
    pvp_pkg::pvp_ctrl_type                      ctrl;
    pvp_pkg::pvp_slot_cfg_type [NUM_SLOTS-1:0]  slotCfg;
    logic [NUM_SLOTS-1:0][15:0]                 txData;
    logic [NUM_SLOTS-1:0][15:0]                 txHold;
    logic [NUM_SLOTS-1:0][15:0]                 rxSh;
    logic [NUM_SLOTS-1:0][15:0]                 rxLin;
    logic [NUM_SLOTS-1:0][7:0]                  air;
    pvp_pkg::pvp_pins_type                      pinMeta;
    pvp_pkg::pvp_pins_type                      pinSync;
    pvp_pkg::pvp_pins_type                      pinOut;
    pvp_pkg::pvp_pins_type                      pinOe;
    logic                                       clkPrev;
    logic [8:0]                                 bitCnt;
    logic                                       framed;
    logic [7:0]                                 frameCnt;
    logic                                       waitReq;
    logic [31:0]                                rdData;
  } pvp_state_type;

  pvp_state_type s;
  pvp_state_type n;

  logic                       genClk;
  logic                       genSync;
  logic                       lawCodec;
  logic [4:0]                 slotWidth;
  logic [15:0]                linMask;
  logic [NUM_SLOTS-1:0]       inSlot;
  logic [NUM_SLOTS-1:0]       lastBit;
  logic [NUM_SLOTS-1:0]       txBit;
  logic [NUM_SLOTS-1:0]       rxOk;
  logic [NUM_SLOTS-1:0][15:0] rxNew;
  logic [NUM_SLOTS-1:0][15:0] rxLinNew;
  logic [NUM_SLOTS-1:0][7:0]  airNew;

  // Master clock and sync source, idle while the port is a slave
  // master by default
  pvp_bclk_gen uBclk
  (
    .clk       (clk),
    .rst       (rst),
    .genEn     (s.ctrl.enable & ~s.ctrl.slaveRole),
    .fastRate  (s.ctrl.fastRate),
    .bitClk    (genClk),
    .frameSync (genSync)
  );

  // Companded formats use eight bits a slot, linear the programmed width
  // codec format select
  assign lawCodec  = (s.ctrl.codecFmt == pvp_pkg::FMT_MULAW) ||
                     (s.ctrl.codecFmt == pvp_pkg::FMT_ALAW);
  assign slotWidth = lawCodec ? `PVP_LAW_BITS : s.ctrl.linWidth;
  assign linMask   = 16'hFFFF << (5'h10 - slotWidth);

  // Per-slot position, bit selection and sample conversion
  for (genvar i = 0; i < NUM_SLOTS; i++)
  begin : gSlot
    logic [8:0]  rel;
    logic [15:0] txWord;
    logic [7:0]  txCode;
    logic [15:0] rxDec;
    logic [7:0]  airCode;
    logic        inBit;
    logic [15:0] rxCur;

    assign rel = s.bitCnt - {1'b0, s.slotCfg[i].startBit};
    assign inSlot[i] = s.slotCfg[i].enable & s.framed &
                       (s.bitCnt >= {1'b0, s.slotCfg[i].startBit}) &
                       (rel < {4'h0, slotWidth});
    assign lastBit[i] = inSlot[i] & (rel == {4'h0, slotWidth - 5'h01});

    assign txWord   = lawCodec ? {txCode, 8'h00} : s.txHold[i];
    assign txBit[i] = txWord[4'hF - rel[3:0]];

    // capture only from a line set as input
    assign inBit   = s.slotCfg[i].rxOnB ? s.pinSync.b : s.pinSync.a;
    assign rxOk[i] = s.slotCfg[i].rxOnB ? ~s.ctrl.bOut : ~s.ctrl.aOut;

    // Shift word with the current bit dropped into place
    always_comb
    begin
      rxCur = s.rxSh[i];
      rxCur[4'hF - rel[3:0]] = inBit;
    end
    assign rxNew[i] = rxCur;

    pvp_law uCodec
    (
      .linIn   (s.txHold[i]),
      .codeIn  (rxNew[i][15:8]),
      .isAlaw  (s.ctrl.codecFmt == pvp_pkg::FMT_ALAW),
      .codeOut (txCode),
      .linOut  (rxDec)
    );
    assign rxLinNew[i] = lawCodec ? rxDec : (rxNew[i] & linMask);

    // air encoding, independent of the codec format
    pvp_law uAir
    (
      .linIn   (rxLinNew[i]),
      .codeIn  (8'h00),
      .isAlaw  (s.ctrl.airEnc == pvp_pkg::AIR_ALAW),
      .codeOut (airCode),
      .linOut  ()
    );
    assign airNew[i] = (s.ctrl.airEnc == pvp_pkg::AIR_CVSD) ?
      {7'h00, $signed(rxLinNew[i]) > $signed(s.rxLin[i])} : airCode;
  end

  // Byte-lane merge for Avalon writes
  function automatic logic [31:0] mergeBe(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    mergeBe = old;
    for (int k = 0; k < 4; k++)
      if (be[k])
        mergeBe[k*8 +: 8] = wd[k*8 +: 8];
  endfunction

  // Next state: pin sampling, frame timing, slots and register access
  always_comb
  begin
    logic        rise;
    logic        fall;
    logic        slotHit;
    logic [2:0]  idx;
    logic [31:0] rd;
    logic [31:0] wv;
    logic        outA;
    logic        outB;
    rise = 1'b0;
    fall = 1'b0;
    slotHit = 1'b0;
    idx = 3'h0;
    rd = 32'h00000000;
    wv = 32'h00000000;
    outA = 1'b0;
    outB = 1'b0;
    n = s;

    // two-flop sampling of all four lines
    n.pinMeta = pinIn;
    n.pinSync = s.pinMeta;
    n.clkPrev = s.pinSync.clk;
    rise = s.pinSync.clk & ~s.clkPrev;
    fall = ~s.pinSync.clk & s.clkPrev;

    // clock and sync driven only as master
    n.pinOut.clk  = genClk;
    n.pinOut.sync = genSync;
    n.pinOe.clk   = s.ctrl.enable & ~s.ctrl.slaveRole;
    n.pinOe.sync  = s.ctrl.enable & ~s.ctrl.slaveRole;
    n.pinOe.a = s.ctrl.enable & s.ctrl.aOut;
    n.pinOe.b = s.ctrl.enable & s.ctrl.bOut;

    if (rise)
    begin
      for (int i = 0; i < NUM_SLOTS; i++)
      begin
        outA = outA | (inSlot[i] & ~s.slotCfg[i].txOnB & txBit[i]);
        outB = outB | (inSlot[i] & s.slotCfg[i].txOnB & txBit[i]);
      end
      n.pinOut.a = outA;
      n.pinOut.b = outB;
    end

    if (fall)
    begin
      // sync high at the falling edge starts a frame
      if (s.pinSync.sync)
      begin
        n.bitCnt = 9'h000;
        n.framed = 1'b1;
        n.txHold = s.txData;
        n.frameCnt = s.frameCnt + 8'h01;
      end
      else
      begin
        for (int i = 0; i < NUM_SLOTS; i++)
          if (inSlot[i] && rxOk[i])
          begin
            n.rxSh[i] = rxNew[i];
            if (lastBit[i])
            begin
              n.rxLin[i] = rxLinNew[i];
              n.air[i] = airNew[i];
              n.rxSh[i] = 16'h0000;
            end
          end
        if (s.bitCnt != 9'h1FF)
          n.bitCnt = s.bitCnt + 9'h001;
      end
    end

    if (!s.ctrl.enable)
    begin
      n.framed = 1'b0;
      n.pinOut.a = 1'b0;
      n.pinOut.b = 1'b0;
    end

    // Register decode
    slotHit = (address >= `PVP_OFS_SLOT_BASE) && (address < SLOT_END) &&
              (address[1:0] == 2'b00);
    idx = 3'((address - `PVP_OFS_SLOT_BASE) >> 3);
    if (address == `PVP_OFS_CTRL)
      rd = s.ctrl;
    else if (address == `PVP_OFS_STATUS)
      rd = {16'h0000, s.frameCnt, 6'h00, s.ctrl.slaveRole, s.framed};
    else if (slotHit && !address[2])
      rd = s.slotCfg[idx];
    else if (slotHit)
      rd = {8'h00, s.air[idx], s.rxLin[idx]};

    // One wait cycle, then the answer
    n.waitReq = 1'b1;
    if ((read || write) && s.waitReq)
    begin
      n.waitReq = 1'b0;
      n.rdData = read ? rd : s.rdData;
    end

    // Writes take effect on the edge after the wait ends, where waitrequest is sampled low
    if (write && !s.waitReq)
    begin
      if (address == `PVP_OFS_CTRL)
      begin
        wv = mergeBe(s.ctrl, writedata, byteenable);
        n.ctrl = wv;
        n.ctrl.rsvdHi = '0;
        n.ctrl.rsvdLo = 1'b0;
        // linear width kept within 13 to 16
        if (n.ctrl.linWidth < `PVP_LIN_MIN)
          n.ctrl.linWidth = `PVP_LIN_MIN;
        else if (n.ctrl.linWidth > `PVP_LIN_MAX)
          n.ctrl.linWidth = `PVP_LIN_MAX;
      end
      else if (slotHit && !address[2])
      begin
        wv = mergeBe(s.slotCfg[idx], writedata, byteenable);
        n.slotCfg[idx] = wv;
        n.slotCfg[idx].rsvdHi = '0;
        n.slotCfg[idx].rsvdLo = '0;
      end
      else if (slotHit)
      begin
        wv = mergeBe({16'h0000, s.txData[idx]}, writedata, byteenable);
        n.txData[idx] = wv[15:0];
      end
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
      s.ctrl <= `PVP_CTRL_RESET;
      s.slotCfg <= {NUM_SLOTS{`PVP_SLOT_RESET}};
      s.waitReq <= 1'b1;
    end
    else
      s <= n;
  end

  // Outputs straight from the state register
  assign readdata    = s.rdData;
  assign waitrequest = s.waitReq;
  assign pinOut      = s.pinOut;
  assign pinOe       = s.pinOe;

endmodule
`default_nettype wire

// File: pvp_voice_port_checker.sv
// Bus and line timing assertions for the PCM voice port
`default_nettype none
module pvp_voice_port_checker
#(
  parameter int NUM_SLOTS = 3
)
(
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic [7:0]            address,
  input wire logic                  read,
  input wire logic                  write,
  input wire logic [31:0]           writedata,
  input wire logic [3:0]            byteenable,
  input wire logic [31:0]           readdata,
  input wire logic                  waitrequest,
  input wire pvp_pkg::pvp_pins_type pinIn,
  input wire pvp_pkg::pvp_pins_type pinOut,
  input wire pvp_pkg::pvp_pins_type pinOe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic        syncQ_r;
  logic        seen_r;
  logic [11:0] syncCnt_r;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Cycles since the last sync rise; a control write restarts the measure
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      syncQ_r <= 1'b0;
      seen_r <= 1'b0;
      syncCnt_r <= 12'h000;
    end
    else
    begin
      syncQ_r <= pinOut.sync;
      if (write && address == 8'h00)
        seen_r <= 1'b0;
      else if (pinOut.sync && !syncQ_r)
        seen_r <= pinOe.sync;
      syncCnt_r <= (pinOut.sync && !syncQ_r) ? 12'h000 : syncCnt_r + 12'h001;
    end
  end
  a_wait_one_cycle: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer not after one wait cycle");
  a_ack_single: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low too long");
  a_idle_no_ack: assert property (!(read || write) |=> waitrequest)
    else $error("answer without request");
  a_hole_reads_zero: assert property (read && address == 8'h08 && !waitrequest
    |-> readdata == 32'h0) else $error("unmapped read not zero");
  a_oe_clk_sync: assert property (pinOe.clk == pinOe.sync)
    else $error("clock and sync drive differ");
  a_clk_high_min: assert property ($rose(pinOut.clk) && pinOe.clk
    |-> (pinOut.clk || !pinOe.clk)[*4]) else $error("bit clock high too short");
  a_clk_high_max: assert property ($rose(pinOut.clk) && pinOe.clk
    |-> ##[1:6] (!pinOut.clk || !pinOe.clk)) else $error("bit clock high too long");
  a_frame_period: assert property (pinOut.sync && !syncQ_r && seen_r && pinOe.sync
    |-> syncCnt_r == 12'h9C3) else $error("frame period not 2500 cycles");
  a_sync_on_rise: assert property ($rose(pinOut.sync) && pinOe.sync
    |-> $rose(pinOut.clk)) else $error("sync not launched with clock rise");
  a_launch_after_rise: assert property ($changed(pinOut.a) && pinOe.a && $past(pinOe.a)
    |-> pinIn.clk) else $error("data changed while bit clock low");
endmodule
bind pvp_voice_port pvp_voice_port_checker #(.NUM_SLOTS(NUM_SLOTS)) u_chk
(
  .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe)
);
`default_nettype wire
